// >>> pkg/xlate_req_pkg.sv
// constants, field layouts and carriers of the address translation request registers
// assumes a 32-bit Avalon-MM register bus and an external translation engine
package xlate_req_pkg;

  // ****************************************
  // bus and map
  // ****************************************
  localparam int unsigned BUS_ADDR_W  = 8;
  localparam int unsigned BUS_DATA_W  = 32;
  localparam logic [7:0] OFS_S1_UR     = 8'h00;
  localparam logic [7:0] OFS_S1_UW     = 8'h08;
  localparam logic [7:0] OFS_S12_PR    = 8'h10;
  localparam logic [7:0] OFS_S12_PW    = 8'h18;
  localparam logic [7:0] OFS_S12_UR    = 8'h20;
  localparam logic [7:0] OFS_REQ_END   = 8'h28;
  localparam logic [7:0] OFS_STATUS    = 8'h80;
  localparam logic [7:0] OFS_RESULT_LO = 8'h88;
  localparam logic [7:0] OFS_RESULT_HI = 8'h8C;
  localparam logic [7:0] ALIAS_BIT     = 8'h40;
  localparam logic [3:0] BYTEEN_FULL   = 4'hF;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int unsigned IN_ADDR_W      = 52;
  localparam int unsigned LO_ADDR_W      = 20;
  localparam int unsigned ADDR_FIELD_LSB = 12;
  localparam int unsigned NDX_MSB        = 7;
  localparam int unsigned ACTIVE_BIT     = 0;
  localparam logic        WAITREQ_RST    = 1'b1;
  localparam logic [63:0] RESULT_RST     = 64'h0;
  localparam logic [31:0] READ_ZERO      = 32'h0;

  typedef enum logic [2:0] {KIND_S1_UR, KIND_S1_UW, KIND_S12_PR, KIND_S12_PW,
                            KIND_S12_UR} req_kind_e;

  typedef struct packed {
    logic [BUS_ADDR_W-1:0] address;
    logic                  read;
    logic                  write;
    logic [31:0]           writedata;
    logic [3:0]            byteenable;
    logic                  secure;
  } bus_cmd_s;

  typedef struct packed {
    logic [IN_ADDR_W-1:0] in_addr;
    logic [7:0]           context_bank_index;
    logic                 two_stage;
    logic                 privileged;
    logic                 is_write;
    logic                 secure;
  } xlate_req_s;

  typedef struct packed {
    logic two_stage;
    logic privileged;
    logic is_write;
  } kind_attr_s;

  typedef struct packed {
    logic      is_req;
    logic      is_status;
    logic      is_res_lo;
    logic      is_res_hi;
    logic      alias_view;
    logic      high_word;
    req_kind_e kind;
  } reg_hit_s;

  function automatic kind_attr_s kind_attr(input req_kind_e k);
    kind_attr_s a;
    a = '0;
    case (k)
      KIND_S1_UR:  a = '{two_stage: 1'b0, privileged: 1'b0, is_write: 1'b0};
      KIND_S1_UW:  a = '{two_stage: 1'b0, privileged: 1'b0, is_write: 1'b1};
      KIND_S12_PR: a = '{two_stage: 1'b1, privileged: 1'b1, is_write: 1'b0};
      KIND_S12_PW: a = '{two_stage: 1'b1, privileged: 1'b1, is_write: 1'b1};
      KIND_S12_UR: a = '{two_stage: 1'b1, privileged: 1'b0, is_write: 1'b0};
      default:     a = '0;
    endcase
    return a;
  endfunction

  function automatic reg_hit_s decode(input logic [BUS_ADDR_W-1:0] addr);
    reg_hit_s             h;
    logic [BUS_ADDR_W-1:0] base;
    h = '0;
    base = addr & ~ALIAS_BIT;
    h.alias_view = addr[6];
    if (addr[1:0] == 2'b00) begin
      if (base < OFS_REQ_END) begin
        h.is_req = 1'b1;
        h.high_word = base[2];
        h.kind = req_kind_e'(base[5:3]);
      end
      h.is_status = (base == OFS_STATUS);
      h.is_res_lo = (base == OFS_RESULT_LO);
      h.is_res_hi = (base == OFS_RESULT_HI);
    end
    return h;
  endfunction

endpackage

// >>> logic/xlate_bank.sv
// one security copy: in-progress flag and latest translation result
// assumes start and done are one-cycle pulses from the request front end
`timescale 1ns/1ps

module xlate_bank
  import xlate_req_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        start,
  input  wire logic        done,
  input  wire logic [63:0] result_in,
  output logic             active,
  output logic [63:0]      result
);

  typedef struct packed {
    logic        active;
    logic [63:0] result;
  } bank_state_s;

  bank_state_s s;
  bank_state_s next_s;

  // ****************************************
  // state update
  // ****************************************
  always_comb begin
    next_s = s;
    if (done) begin
      next_s.result = result_in;
      next_s.active = 1'b0;
    end
    if (start) begin
      next_s.active = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{active: 1'b0, result: RESULT_RST};
    end else begin
      s <= next_s;
    end
  end

  assign active = s.active;
  assign result = s.result;

  // ****************************************
  // checks
  // ****************************************
  property p_bank_result;
    @(posedge mclk) disable iff (!arst_n)
    done |=> (result == $past(result_in));
  endproperty
  a_bank_result: assert property (p_bank_result) else $error("result not stored on done");

endmodule

// >>> logic/xlate_req_regs.sv
// address translation request registers behind an Avalon-MM slave
// assumes one translation engine taking valid/ready requests and answering with a done pulse
//
// The Avalon-MM slave port and the register offsets were decided locally.
`timescale 1ns/1ps

module xlate_req_regs
  import xlate_req_pkg::*;
#(
  parameter bit ARCH_V2    = 1'b1,
  parameter bit TWO_SEC    = 1'b1,
  parameter bit IMPLEMENT  = 1'b1
)(
  input  wire logic                     mclk,
  input  wire logic                     arst_n,
  input  wire xlate_req_pkg::bus_cmd_s  bus_cmd,
  output logic                          avs_waitrequest,
  output logic [31:0]                   avs_readdata,
  output logic                          xlate_valid,
  output xlate_req_pkg::xlate_req_s     xlate_req,
  input  wire logic                     xlate_ready,
  input  wire logic                     xlate_done,
  input  wire logic [63:0]              xlate_result
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (BUS_ADDR_W < 8) begin : g_bad_addr
    $error("register map needs at least 8 address bits");
  end
  if (BUS_DATA_W != 32) begin : g_bad_data
    $error("register bus must be 32 bits wide");
  end

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
    logic        xlate_valid;
    xlate_req_s  req;
    logic        busy;
    logic        owner;
  } front_state_s;

  front_state_s s;
  front_state_s next_s;

  reg_hit_s    hit;
  kind_attr_s  attr;
  logic        target_secure;
  logic        alias_ok;
  logic        accept_wr;
  logic        req_wr;
  logic        start;
  logic [31:0] rd_word;
  logic [1:0]  bank_start;
  logic [1:0]  bank_done;
  logic [1:0]  bank_active;
  logic [63:0] bank_result [2];

  // ****************************************
  // decode and bank choice
  // ****************************************
  always_comb begin
    hit = decode(bus_cmd.address);
    attr = kind_attr(hit.kind);
    target_secure = TWO_SEC && !hit.alias_view && bus_cmd.secure;
    alias_ok = !hit.alias_view || (TWO_SEC && bus_cmd.secure);
  end

  // write effect happens at the edge where the master sees waitrequest low
  assign accept_wr = bus_cmd.write && !s.waitrequest;

  assign req_wr = IMPLEMENT && accept_wr && hit.is_req && alias_ok && !hit.high_word
                  && (bus_cmd.byteenable == BYTEEN_FULL);

  // overlap is unpredictable; dropping it keeps the engine consistent
  // no overlap honoured
  assign start = req_wr && !s.busy;

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rd_word = READ_ZERO;
    if (alias_ok) begin
      if (hit.is_status) begin
        rd_word[ACTIVE_BIT] = bank_active[target_secure];
      end else if (hit.is_res_lo) begin
        rd_word = bank_result[target_secure][31:0];
      end else if (hit.is_res_hi) begin
        rd_word = bank_result[target_secure][63:32];
      end
    end
  end

  // ****************************************
  // front-end state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.waitrequest = WAITREQ_RST;
    next_s.readdata = READ_ZERO;
    if ((bus_cmd.read || bus_cmd.write) && s.waitrequest) begin
      next_s.waitrequest = 1'b0;
      if (bus_cmd.read) begin
        next_s.readdata = rd_word;
      end
    end
    if (s.xlate_valid && xlate_ready) begin
      next_s.xlate_valid = 1'b0;
    end
    if (xlate_done && s.busy) begin
      next_s.busy = 1'b0;
    end
    if (start) begin
      next_s.xlate_valid = 1'b1;
      next_s.busy = 1'b1;
      next_s.owner = target_secure;
      next_s.req.in_addr = '0;
      next_s.req.in_addr[LO_ADDR_W-1:0] = bus_cmd.writedata[31:ADDR_FIELD_LSB];
      next_s.req.context_bank_index = bus_cmd.writedata[NDX_MSB:0];
      next_s.req.two_stage = attr.two_stage;
      next_s.req.privileged = attr.privileged;
      next_s.req.is_write = attr.is_write;
      next_s.req.secure = target_secure;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{waitrequest: WAITREQ_RST, readdata: READ_ZERO, xlate_valid: 1'b0,
             req: '0, busy: 1'b0, owner: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest = s.waitrequest;
  assign avs_readdata = s.readdata;
  assign xlate_valid = s.xlate_valid;
  assign xlate_req = s.req;

  // ****************************************
  // security copies
  // ****************************************
  for (genvar b = 0; b < 2; b++) begin : g_bank
    assign bank_start[b] = start && (target_secure == 1'(b));
    assign bank_done[b] = xlate_done && s.busy && (s.owner == 1'(b));
    xlate_bank u_bank (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .start     (bank_start[b]),
      .done      (bank_done[b]),
      .result_in (xlate_result),
      .active    (bank_active[b]),
      .result    (bank_result[b])
    );
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_start_on_write;
    start |=> xlate_valid && s.busy;
  endproperty
  a_start_on_write: assert property (p_start_on_write) else $error("write did not start");

  property p_zero_ext;
    start |=> (xlate_req.in_addr[IN_ADDR_W-1:LO_ADDR_W] == '0);
  endproperty
  a_zero_ext: assert property (p_zero_ext) else $error("address not zero-extended");

  property p_high_ignored;
    (accept_wr && hit.is_req && hit.high_word && !s.xlate_valid && !s.busy)
      |=> !xlate_valid ##1 !xlate_valid;
  endproperty
  a_high_ignored: assert property (p_high_ignored) else $error("high word started work");

  property p_bank_select;
    (start && bus_cmd.secure && !hit.alias_view) |=> (xlate_req.secure == TWO_SEC);
  endproperty
  a_bank_select: assert property (p_bank_select) else $error("wrong security copy");

  property p_alias_ns;
    (accept_wr && hit.is_req && hit.alias_view && !alias_ok && !s.xlate_valid && !s.busy)
      |=> !xlate_valid;
  endproperty
  a_alias_ns: assert property (p_alias_ns) else $error("alias open to non-secure");

  property p_alias_copy;
    (start && hit.alias_view) |=> !xlate_req.secure && bank_active[0];
  endproperty
  a_alias_copy: assert property (p_alias_copy) else $error("alias hit secure copy");

  property p_absent;
    !IMPLEMENT |-> !xlate_valid;
  endproperty
  a_absent: assert property (p_absent) else $error("request without requests built");

  property p_write_only;
    (bus_cmd.read && s.waitrequest && hit.is_req) |=> !avs_waitrequest && avs_readdata == '0;
  endproperty
  a_write_only: assert property (p_write_only) else $error("request register readable");

  property p_addr_field;
    start |=> (xlate_req.in_addr[LO_ADDR_W-1:0] == $past(bus_cmd.writedata[31:12]));
  endproperty
  a_addr_field: assert property (p_addr_field) else $error("wrong address field");

  property p_index;
    start |=> (xlate_req.context_bank_index == $past(bus_cmd.writedata[7:0]));
  endproperty
  a_index: assert property (p_index) else $error("wrong context index");

  property p_s1_ur;
    (start && hit.kind == KIND_S1_UR)
      |=> !xlate_req.two_stage && !xlate_req.privileged && !xlate_req.is_write;
  endproperty
  a_s1_ur: assert property (p_s1_ur) else $error("stage-1 user read mis-typed");

  property p_s12_pw;
    (start && hit.kind == KIND_S12_PW)
      |=> xlate_req.two_stage && xlate_req.privileged && xlate_req.is_write;
  endproperty
  a_s12_pw: assert property (p_s12_pw) else $error("two-stage priv write mis-typed");

  property p_active_pending;
    xlate_valid |-> bank_active[xlate_req.secure];
  endproperty
  a_active_pending: assert property (p_active_pending) else $error("flag low while pending");

  property p_status_read;
    (bus_cmd.read && s.waitrequest && hit.is_status && alias_ok)
      |=> avs_readdata[0] == $past(bank_active[target_secure]);
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bit wrong");

  property p_answer_one;
    (bus_cmd.read || bus_cmd.write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer_one: assert property (p_answer_one) else $error("bus answer timing wrong");

  c_start:      cover property (start);
  c_done:       cover property (xlate_done && s.busy);
  c_alias:      cover property (start && hit.alias_view);
  c_high_write: cover property (accept_wr && hit.is_req && hit.high_word);

endmodule

// >>> tb/xlate_req_regs_test.sv
// self-checking bench for the translation request registers
// assumes the bench acts as bus master and as translation engine
`timescale 1ns/1ps

module xlate_req_regs_test;
  import xlate_req_pkg::*;

  logic        mclk;
  logic        arst_n;
  bus_cmd_s    bus_cmd;
  logic        avs_waitrequest;
  logic [31:0] avs_readdata;
  logic        xlate_valid;
  xlate_req_s  xlate_req;
  logic        xlate_ready;
  logic        xlate_done;
  logic [63:0] xlate_result;
  int          err_total;
  int          samples_checked;
  logic [7:0]  ofs [5];
  logic [2:0]  attr [5];
  logic [63:0] last_res [2];
  logic        none_valid;

  xlate_req_regs dut (
    .mclk            (mclk),
    .arst_n          (arst_n),
    .bus_cmd         (bus_cmd),
    .avs_waitrequest (avs_waitrequest),
    .avs_readdata    (avs_readdata),
    .xlate_valid     (xlate_valid),
    .xlate_req       (xlate_req),
    .xlate_ready     (xlate_ready),
    .xlate_done      (xlate_done),
    .xlate_result    (xlate_result)
  );

  // same bus traffic into a build without request registers
  xlate_req_regs #(
    .IMPLEMENT (1'b0)
  ) dut_none (
    .mclk            (mclk),
    .arst_n          (arst_n),
    .bus_cmd         (bus_cmd),
    .avs_waitrequest (),
    .avs_readdata    (),
    .xlate_valid     (none_valid),
    .xlate_req       (),
    .xlate_ready     (xlate_ready),
    .xlate_done      (xlate_done),
    .xlate_result    (xlate_result)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    err_total++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic bus_op(input logic [7:0] a, input logic rd, input logic [31:0] d,
                        input logic [3:0] be, input logic s, output logic [31:0] q);
    int n;
    @(posedge mclk);
    bus_cmd <= '{address: a, read: rd, write: ~rd, writedata: d, byteenable: be, secure: s};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) hang();
    q = avs_readdata;
    bus_cmd <= '0;
  endtask

  task automatic wait_valid(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (xlate_valid !== lvl && n < 50);
    if (n >= 50) hang();
  endtask

  // one full translation: request, status, engine answer, result
  task automatic do_xlate(input int k, input logic [31:0] d, input logic s,
                          input logic al, input logic [63:0] res);
    logic [7:0]  av;
    logic [31:0] q;
    logic        es;
    av = al ? ALIAS_BIT : 8'h00;
    es = s & ~al;
    bus_op(ofs[k] | av, 1'b0, d, BYTEEN_FULL, s, q);
    wait_valid(1'b1);
    check(64'(xlate_req.in_addr), 64'(d[31:12]));
    check(64'(xlate_req.context_bank_index), 64'(d[7:0]));
    check(64'({xlate_req.two_stage, xlate_req.privileged, xlate_req.is_write}), 64'(attr[k]));
    check(64'(xlate_req.secure), 64'(es));
    check(64'(none_valid), 64'h0);
    bus_op(OFS_STATUS | av, 1'b1, 32'h0, BYTEEN_FULL, s, q);
    check(64'(q), 64'h1);
    if (es) begin
      bus_op(OFS_STATUS | ALIAS_BIT, 1'b1, 32'h0, BYTEEN_FULL, 1'b1, q);
      check(64'(q), 64'h0);
    end
    // engine accepts, then answers a little later
    // done before next request
    @(posedge mclk);
    xlate_ready <= 1'b1;
    wait_valid(1'b0);
    @(posedge mclk);
    xlate_ready  <= 1'b0;
    xlate_done   <= 1'b1;
    xlate_result <= res;
    @(posedge mclk);
    xlate_done   <= 1'b0;
    xlate_result <= ~res;
    last_res[es] = res;
    bus_op(OFS_STATUS | av, 1'b1, 32'h0, BYTEEN_FULL, s, q);
    check(64'(q), 64'h0);
    bus_op(OFS_RESULT_LO | av, 1'b1, 32'h0, BYTEEN_FULL, s, q);
    check(64'(q), 64'(res[31:0]));
    bus_op(OFS_RESULT_HI | av, 1'b1, 32'h0, BYTEEN_FULL, s, q);
    check(64'(q), 64'(res[63:32]));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_idle();
    logic [31:0] q;
    bus_op(OFS_STATUS, 1'b1, 32'h0, BYTEEN_FULL, 1'b1, q);
    check(64'(q), 64'h0);
    bus_op(OFS_RESULT_LO, 1'b1, 32'h0, BYTEEN_FULL, 1'b0, q);
    check(64'(q), RESULT_RST);
    $display("test idle done");
  endtask

  task automatic test_kinds();
    logic [31:0] q;
    for (int k = 0; k < 5; k++) begin
      do_xlate(k, {20'hC3A50 + 20'(k), 4'hF, 8'hE0 + 8'(k)}, k[0], 1'b0,
               {32'h5A000000 + 32'(k), 32'hF00D0000 + 32'(k)});
    end
    // each copy keeps its own last result
    bus_op(OFS_RESULT_LO, 1'b1, 32'h0, BYTEEN_FULL, 1'b1, q);
    check(64'(q), 64'(last_res[1][31:0]));
    bus_op(OFS_RESULT_LO, 1'b1, 32'h0, BYTEEN_FULL, 1'b0, q);
    check(64'(q), 64'(last_res[0][31:0]));
    $display("test kinds done");
  endtask

  task automatic test_alias();
    logic [31:0] q;
    do_xlate(1, 32'hFFFFF5AB, 1'b1, 1'b1, 64'h0123456789ABCDEF);
    bus_op(OFS_RESULT_HI, 1'b1, 32'h0, BYTEEN_FULL, 1'b0, q);
    check(64'(q), 64'h01234567);
    $display("test alias done");
  endtask

  // high word, partial enables, non-secure alias, unmapped: all dropped
  task automatic test_refused();
    logic [7:0]  wa [4];
    logic [3:0]  wb [4];
    logic [31:0] q;
    wa = '{OFS_S1_UR + 8'h04, OFS_S12_PR, OFS_S12_PW | ALIAS_BIT, 8'h30};
    wb = '{BYTEEN_FULL, 4'h7, BYTEEN_FULL, BYTEEN_FULL};
    for (int i = 0; i < 4; i++) begin
      bus_op(wa[i], 1'b0, 32'hABCDE123, wb[i], 1'b0, q);
      repeat (4) @(posedge mclk);
      check(64'(xlate_valid), 64'h0);
      bus_op(OFS_STATUS, 1'b1, 32'h0, BYTEEN_FULL, 1'b0, q);
      check(64'(q), 64'h0);
    end
    bus_op(OFS_S12_UR, 1'b1, 32'h0, BYTEEN_FULL, 1'b1, q);
    check(64'(q), 64'h0);
    $display("test refused done");
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    arst_n          = 1'b0;
    bus_cmd         = '0;
    xlate_ready     = 1'b0;
    xlate_done      = 1'b0;
    xlate_result    = 64'h0;
    err_total       = 0;
    samples_checked = 0;
    ofs  = '{OFS_S1_UR, OFS_S1_UW, OFS_S12_PR, OFS_S12_PW, OFS_S12_UR};
    attr = '{3'b000, 3'b001, 3'b110, 3'b111, 3'b100};
    repeat (8) @(posedge mclk);
    check(64'({avs_waitrequest, xlate_valid}), 64'h2);
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    test_idle();
    test_kinds();
    test_alias();
    test_refused();
    report_and_stop();
  end
endmodule
